// ### dbr_pkg.sv
// package of constants and types for the dma bus request sequencer
//----------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------
// Summary of operation
// [RULE1] raise the bus request at the first rising edge after a channel activates; the code raises it at the second edge
// [RULE2] sample the bus grant within the same state the request is raised
// [RULE3] present the read or write access request at the rising edge after grant
// [RULE4] request and grant take two states, so transfers are two states apart
// [RULE5] single address transfer: two states activation wait, then the data access
// [RULE6] each of four channels keeps its transfer information in its own registers
// [RULE7] one transfer needs only the handshake plus one access, about 0.1 us at 20 MHz
// [RULE8] port width is left to the bus controller, which splits or joins accesses
// [RULE9] external address keeps its last value during internal space accesses
// [RULE10] count reaching zero clears the enable bit; requests ignored until set again
// [RULE11] edge sensing: first activation after enabling is taken from a low level
// [RULE12] concurrent requests are served one at a time through one shared request
package dbr_pkg;
  //----------------------------------------------------------------
  // widths and counts
  //----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  //----------------------------------------------------------------
  // address stepping and reset values
  //----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000002;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
  localparam logic [ADDR_W-1:0] INT_BASE_DFLT = 24'hff0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  //----------------------------------------------------------------
  // timing
  //----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HANDSHAKE_STATES = 2;
  localparam int MIN_XFER_NS = 100;
  localparam int MIN_XFER_CYC = (MIN_XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  //----------------------------------------------------------------
  // sequencer states
  //----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_ACC1,
    ST_ACC2
  } dbr_state_type;
endpackage

// ### dbr_sequencer.sv
// four channel dma bus request sequencer facing the internal bus controller
`timescale 1ns/1ps
`default_nettype none
module dbr_sequencer #(
  parameter int NUM_CH = dbr_pkg::NUM_CH,
  parameter logic [dbr_pkg::ADDR_W-1:0] INT_BASE = dbr_pkg::INT_BASE_DFLT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // channel set up, one load strobe per channel
  input wire logic [NUM_CH-1:0] cfg_load,
  input wire logic [dbr_pkg::ADDR_W-1:0] cfg_src,
  input wire logic [dbr_pkg::ADDR_W-1:0] cfg_dst,
  input wire logic [dbr_pkg::CNT_W-1:0] cfg_count,
  input wire logic cfg_edge_sense,
  input wire logic cfg_single,
  input wire logic cfg_single_write,
  input wire logic [NUM_CH-1:0] channel_transfer_enable_set,
  // activation sources
  input wire logic [NUM_CH-1:0] external_transfer_request_pin_n,
  input wire logic [NUM_CH-1:0] internal_activation,
  // bus controller side
  output logic bus_req_q,
  input wire logic bus_grant,
  output logic acc_req_q,
  output logic acc_write_q,
  output logic [dbr_pkg::ADDR_W-1:0] acc_addr_q,
  output logic [dbr_pkg::DATA_W-1:0] acc_wdata_q,
  input wire logic [dbr_pkg::DATA_W-1:0] acc_rdata,
  input wire logic acc_done,
  // external address bus
  output logic [dbr_pkg::ADDR_W-1:0] ext_addr_q,
  // status
  output logic [NUM_CH-1:0] channel_transfer_enable_bit_q,
  output logic [NUM_CH-1:0] xfer_end_q
);
  //----------------------------------------------------------------
  // elaboration check
  //----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > dbr_pkg::NUM_CH) begin : g_bad_ch
    $error("dbr_sequencer: NUM_CH must be 1 to 4");
  end

  //----------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------
  dbr_pkg::dbr_state_type state_q, state_d;
  logic [dbr_pkg::ADDR_W-1:0] src_q [NUM_CH];
  logic [dbr_pkg::ADDR_W-1:0] dst_q [NUM_CH];
  logic [dbr_pkg::CNT_W-1:0] cnt_q [NUM_CH];
  logic [NUM_CH-1:0] edge_q, single_q, swr_q, first_q, pend_q, pin_prev_q;
  logic [NUM_CH-1:0] detect, sel_oh;
  logic [1:0] sel_q, pick;
  logic any_pend, grant_take, finish, last_xfer, next_write, next_ext;
  logic [dbr_pkg::ADDR_W-1:0] next_addr;

  //----------------------------------------------------------------
  // selection and decode
  //----------------------------------------------------------------
  // lowest channel wins; one shared request serves one channel at a time
  function automatic logic [1:0] pick_low(input logic [NUM_CH-1:0] p);
    logic [1:0] r;
    r = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // [RULE12] single shared request
  assign pick = pick_low(pend_q);
  assign any_pend = |pend_q;
  // [RULE2] grant sampled while request stands
  assign grant_take = (state_q == dbr_pkg::ST_REQ) && bus_grant;
  // [RULE5] single address mode ends after one access
  assign finish = acc_done && ((state_q == dbr_pkg::ST_ACC2) ||
                  ((state_q == dbr_pkg::ST_ACC1) && single_q[sel_q]));
  // [RULE10] last transfer of the block
  assign last_xfer = (cnt_q[sel_q] == dbr_pkg::CNT_ONE) || (cnt_q[sel_q] == dbr_pkg::CNT_ZERO);
  // [RULE8] word accesses only; width split belongs to the bus controller
  assign next_write = grant_take ? (single_q[sel_q] & swr_q[sel_q]) : 1'b1;
  assign next_addr = grant_take ? src_q[sel_q] : dst_q[sel_q];
  // [RULE9] internal space never shows on the external address bus
  assign next_ext = next_addr < INT_BASE;

  //----------------------------------------------------------------
  // per channel transfer information
  //----------------------------------------------------------------
  // [RULE6] dedicated registers per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic served, done_here, clear_en;
    assign sel_oh[c] = (sel_q == 2'(c));
    assign served = grant_take && sel_oh[c];
    assign done_here = finish && sel_oh[c];
    assign clear_en = done_here && last_xfer;
    // [RULE11] first activation after enabling is level sensed
    assign detect[c] = channel_transfer_enable_bit_q[c] && !clear_en &&
                       (internal_activation[c] || (!external_transfer_request_pin_n[c] &&
                       (!edge_q[c] || first_q[c] || pin_prev_q[c])));

    // channel set up and address stepping
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        src_q[c] <= dbr_pkg::ADDR_RST;
        dst_q[c] <= dbr_pkg::ADDR_RST;
        cnt_q[c] <= dbr_pkg::CNT_ZERO;
        edge_q[c] <= 1'b0;
        single_q[c] <= 1'b0;
        swr_q[c] <= 1'b0;
      end else if (cfg_load[c]) begin
        src_q[c] <= cfg_src;
        dst_q[c] <= cfg_dst;
        cnt_q[c] <= cfg_count;
        edge_q[c] <= cfg_edge_sense;
        single_q[c] <= cfg_single;
        swr_q[c] <= cfg_single_write;
      end else if (done_here) begin
        src_q[c] <= src_q[c] + dbr_pkg::ADDR_STEP;
        dst_q[c] <= single_q[c] ? dst_q[c] : dst_q[c] + dbr_pkg::ADDR_STEP;
        cnt_q[c] <= cnt_q[c] - dbr_pkg::CNT_ONE;
      end
    end

    // enable, first-activation flag, pending request, pin history
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        channel_transfer_enable_bit_q[c] <= 1'b0;
        first_q[c] <= 1'b0;
        pend_q[c] <= 1'b0;
        pin_prev_q[c] <= 1'b1;
        xfer_end_q[c] <= 1'b0;
      end else begin
        // [RULE10] software set wins over the end-of-block clear
        channel_transfer_enable_bit_q[c] <= channel_transfer_enable_set[c] ||
                                            (channel_transfer_enable_bit_q[c] && !clear_en);
        first_q[c] <= channel_transfer_enable_set[c] ||
                      (first_q[c] && !(detect[c] && !external_transfer_request_pin_n[c]));
        // new detection wins over the service clear
        pend_q[c] <= detect[c] || (pend_q[c] && !served && !clear_en);
        pin_prev_q[c] <= external_transfer_request_pin_n[c];
        xfer_end_q[c] <= clear_en;
      end
    end
  end

  //----------------------------------------------------------------
  // request, grant and access sequencer
  //----------------------------------------------------------------
  // next state; the wait for acc_done is the bus controller's to bound
  // [RULE4] request then grant, two states before the first access of each transfer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dbr_pkg::ST_IDLE: begin
        if (any_pend) begin
          state_d = dbr_pkg::ST_REQ;
        end
      end
      dbr_pkg::ST_REQ: begin
        if (bus_grant) begin
          state_d = dbr_pkg::ST_ACC1;
        end
      end
      dbr_pkg::ST_ACC1: begin
        if (acc_done) begin
          state_d = single_q[sel_q] ? dbr_pkg::ST_IDLE : dbr_pkg::ST_ACC2;
        end
      end
      dbr_pkg::ST_ACC2: begin
        if (acc_done) begin
          state_d = dbr_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // [RULE1] request raised two edges after activation, one edge after the pending flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= dbr_pkg::ST_IDLE;
      bus_req_q <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      state_q <= state_d;
      bus_req_q <= (state_d == dbr_pkg::ST_REQ);
      if (state_q == dbr_pkg::ST_IDLE && any_pend) begin
        sel_q <= pick;
      end
    end
  end

  // [RULE3] access request the edge after grant
  // [RULE7] no idle state between grant and access keeps the fast path
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_req_q <= 1'b0;
      acc_write_q <= 1'b0;
      acc_addr_q <= dbr_pkg::ADDR_RST;
      acc_wdata_q <= '0;
      ext_addr_q <= dbr_pkg::ADDR_RST;
    end else if (grant_take || (acc_done && state_q == dbr_pkg::ST_ACC1 && !single_q[sel_q])) begin
      acc_req_q <= 1'b1;
      acc_write_q <= next_write;
      acc_addr_q <= next_addr;
      if (!grant_take) begin
        acc_wdata_q <= acc_rdata;
      end
      // [RULE9] hold external address for internal space
      if (next_ext) begin
        ext_addr_q <= next_addr;
      end
    end else if (finish) begin
      acc_req_q <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_req_after_act: assert property (state_q == dbr_pkg::ST_IDLE && any_pend |=> bus_req_q) // [RULE1]
    else $error("bus request not raised after activation");
  a_grant_same_state: assert property (bus_req_q && bus_grant |=> !bus_req_q && acc_req_q) // [RULE2]
    else $error("grant not taken in the request state");
  a_acc_after_grant: assert property (grant_take |=> acc_req_q && acc_addr_q == $past(src_q[sel_q])) // [RULE3]
    else $error("access request missing after grant");
  a_two_state_gap: assert property ($rose(acc_req_q) |-> $past(bus_req_q)) // [RULE4]
    else $error("access without preceding handshake");
  a_single_one_acc: assert property (acc_done && state_q == dbr_pkg::ST_ACC1 && single_q[sel_q] |=> // [RULE5]
                                     !acc_req_q)
    else $error("single address transfer did not end after one access");
  a_count_step: assert property (finish |=> // [RULE6]
                                 cnt_q[$past(sel_q)] == $past(cnt_q[sel_q]) - dbr_pkg::CNT_ONE)
    else $error("channel count not stepped");
  a_min_xfer: assert property ($rose(bus_req_q) && bus_grant |=> acc_req_q) // [RULE7]
    else $error("fast transfer path broken");
  a_ext_addr_hold: assert property (acc_req_q && acc_addr_q >= INT_BASE |-> $stable(ext_addr_q)) // [RULE9]
    else $error("internal address shown on external bus");
  a_end_clears_en: assert property (xfer_end_q[0] |-> // [RULE10]
                                    !channel_transfer_enable_bit_q[0] || $past(channel_transfer_enable_set[0]))
    else $error("enable bit survived end of block");
  a_no_pend_disabled: assert property (!channel_transfer_enable_bit_q[0] && // [RULE10]
                                       !$past(channel_transfer_enable_bit_q[0]) |-> !pend_q[0])
    else $error("request accepted while disabled");
  // highest channel is the one the edge-sensing scenario drives by its pin
  a_first_level: assert property (channel_transfer_enable_bit_q[NUM_CH-1] && first_q[NUM_CH-1] && // [RULE11]
                                  !external_transfer_request_pin_n[NUM_CH-1] |=>
                                  pend_q[NUM_CH-1] || xfer_end_q[NUM_CH-1])
    else $error("first low level not taken");
  a_one_channel: assert property (acc_req_q |-> $stable(sel_q)) // [RULE12]
    else $error("channel changed during access");

  c_dual_xfer: cover property (state_q == dbr_pkg::ST_ACC2 && acc_done);
  c_single_xfer: cover property (finish && single_q[sel_q]);
  c_block_end: cover property (|xfer_end_q);
  c_two_pending: cover property ($countones(pend_q) > 1);
endmodule
`default_nettype wire

// ### dbr_bus_ctrl_model.sv
// behavioural model of the internal bus controller facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module dbr_bus_ctrl_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // answer delays chosen by the bench
  input wire logic [3:0] grant_dly,
  input wire logic [3:0] done_dly,
  // sequencer side
  input wire logic bus_req_q,
  input wire logic acc_req_q,
  input wire logic [dbr_pkg::ADDR_W-1:0] acc_addr_q,
  output logic bus_grant,
  output logic acc_done,
  output logic [dbr_pkg::DATA_W-1:0] acc_rdata
);
  logic [3:0] gcnt_q;
  logic [3:0] dcnt_q;
  logic done_q;
  logic [dbr_pkg::DATA_W-1:0] word;
  // read word follows the address; inverted outside the done cycle so stale data never matches
  assign word = acc_addr_q[15:0] ^ 16'h5a5a;
  // port width split stays in here, the sequencer sees whole words
  assign acc_rdata = done_q ? word : ~word;
  assign acc_done = done_q;
  // grant in the same state as the request once the wait is over
  assign bus_grant = bus_req_q && (gcnt_q >= grant_dly);
  // wait counters for grant and access completion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gcnt_q <= 4'h0;
      dcnt_q <= 4'h0;
      done_q <= 1'b0;
    end else begin
      gcnt_q <= bus_req_q ? gcnt_q + 4'h1 : 4'h0;
      done_q <= acc_req_q && !done_q && (dcnt_q >= done_dly);
      dcnt_q <= (acc_req_q && !done_q) ? dcnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the dma bus request sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys, arst_n, cfg_edge_sense, cfg_single, cfg_single_write;
  logic [3:0] cfg_load, en_set, pin_n, int_act, grant_dly, done_dly, en_q, end_q;
  logic [23:0] cfg_src, cfg_dst, ext_addr_q, acc_addr_q;
  logic [15:0] cfg_count, acc_wdata_q, acc_rdata;
  logic bus_req_q, bus_grant, acc_req_q, acc_write_q, acc_done;
  logic [23:0] a_log[$];
  logic [15:0] d_log[$];
  logic w_log[$];
  int end_seen[4];
  int bad_count = 0;
  int total_checks = 0;
  dbr_sequencer dbr_sequencer_inst (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_load(cfg_load),
    .cfg_src(cfg_src), .cfg_dst(cfg_dst), .cfg_count(cfg_count), .cfg_edge_sense(cfg_edge_sense),
    .cfg_single(cfg_single), .cfg_single_write(cfg_single_write), .channel_transfer_enable_set(en_set),
    .external_transfer_request_pin_n(pin_n), .internal_activation(int_act), .bus_req_q(bus_req_q),
    .bus_grant(bus_grant), .acc_req_q(acc_req_q), .acc_write_q(acc_write_q), .acc_addr_q(acc_addr_q),
    .acc_wdata_q(acc_wdata_q), .acc_rdata(acc_rdata), .acc_done(acc_done), .ext_addr_q(ext_addr_q),
    .channel_transfer_enable_bit_q(en_q), .xfer_end_q(end_q));
  dbr_bus_ctrl_model dbr_bus_ctrl_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .grant_dly(grant_dly),
    .done_dly(done_dly), .bus_req_q(bus_req_q), .acc_req_q(acc_req_q), .acc_addr_q(acc_addr_q),
    .bus_grant(bus_grant), .acc_done(acc_done), .acc_rdata(acc_rdata));
  // clock, 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // access log taken where the bus controller completes an access; end pulses counted on every clock
  always @(posedge clk_sys) begin
    if (acc_req_q === 1'b1 && acc_done === 1'b1) begin
      a_log.push_back(acc_addr_q);
      w_log.push_back(acc_write_q);
      d_log.push_back(acc_wdata_q);
    end
    for (int i = 0; i < 4; i++) begin
      if (end_q[i] === 1'b1) end_seen[i]++;
    end
  end
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // load one channel, then set its enable bit
  task automatic setup(input int ch, input logic [23:0] s, input logic [23:0] d, input logic [15:0] c,
                       input logic e, input logic sg, input logic sw);
    @(posedge clk_sys);
    cfg_load <= 4'h1 << ch;
    cfg_src <= s;
    cfg_dst <= d;
    cfg_count <= c;
    cfg_edge_sense <= e;
    cfg_single <= sg;
    cfg_single_write <= sw;
    @(posedge clk_sys);
    cfg_load <= 4'h0;
    en_set <= 4'h1 << ch;
    @(posedge clk_sys);
    en_set <= 4'h0;
  endtask
  task automatic wait_log(input int n);
    int k;
    for (k = 0; k < 100 && a_log.size() < n; k++) @(posedge clk_sys);
    chk("access count", 24'(n), 24'(a_log.size()));
  endtask
  // all three logs start empty for each scenario
  task automatic clear_logs();
    a_log.delete();
    w_log.delete();
    d_log.delete();
  endtask
  // dual transfer, prompt answers, handshake timing
  task automatic t_dual();
    int n;
    setup(0, 24'h001000, 24'h002000, 16'h0001, 1'b0, 1'b0, 1'b0);
    int_act[0] <= 1'b1;
    for (n = 0; n < 10 && bus_req_q !== 1'b1; n++) @(posedge clk_sys) #1;
    chk("req delay", 24'd2, 24'(n));
    int_act[0] <= 1'b0;
    @(posedge clk_sys) #1;
    chk("acc after grant", 24'h1, {23'h0, acc_req_q & ~bus_req_q});
    wait_log(2);
    chk("read addr", 24'h001000, a_log[0]);
    chk("write addr", 24'h002000, a_log[1]);
    chk("write data", 24'h004a5a, {8'h0, d_log[1]});
    repeat (3) @(posedge clk_sys);
    chk("enable cleared", 24'h0, {20'h0, en_q});
    chk("end pulses", 24'h1, 24'(end_seen[0]));
    chk("ext addr", 24'h002000, ext_addr_q);
  endtask
  // activation with the enable bit clear is ignored
  task automatic t_refuse();
    clear_logs();
    int_act[0] <= 1'b1;
    repeat (12) @(posedge clk_sys);
    int_act[0] <= 1'b0;
    chk("ignored", 24'h0, 24'(a_log.size()));
  endtask
  // two channels at once, slow bus controller
  task automatic t_pair();
    clear_logs();
    grant_dly <= 4'h3;
    done_dly <= 4'h2;
    setup(1, 24'h003000, 24'h004000, 16'h0001, 1'b0, 1'b0, 1'b0);
    setup(2, 24'h005000, 24'h006000, 16'h0001, 1'b0, 1'b0, 1'b0);
    int_act <= 4'h6;
    wait_log(4);
    int_act <= 4'h0;
    chk("first src", 24'h003000, a_log[0]);
    chk("first dst", 24'h004000, a_log[1]);
    chk("second src", 24'h005000, a_log[2]);
    chk("second dst", 24'h006000, a_log[3]);
    grant_dly <= 4'h0;
    done_dly <= 4'h0;
  endtask
  // single read of an internal address keeps the external bus
  task automatic t_internal();
    clear_logs();
    setup(0, 24'hff0100, 24'h000000, 16'h0001, 1'b0, 1'b1, 1'b0);
    int_act[0] <= 1'b1;
    wait_log(1);
    int_act[0] <= 1'b0;
    chk("single read", 24'h0, {23'h0, w_log[0]});
    chk("ext addr held", 24'h006000, ext_addr_q);
  endtask
  // edge sensing with the pin already low when enabled
  task automatic t_edge();
    clear_logs();
    pin_n[3] <= 1'b0;
    setup(3, 24'h007000, 24'h000000, 16'h0002, 1'b1, 1'b1, 1'b1);
    wait_log(1);
    repeat (20) @(posedge clk_sys);
    chk("no retrigger", 24'h1, 24'(a_log.size()));
    chk("single write", 24'h1, {23'h0, w_log[0]});
    pin_n[3] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    pin_n[3] <= 1'b0;
    wait_log(2);
    chk("stepped addr", 24'h007002, a_log[1]);
    repeat (3) @(posedge clk_sys);
    chk("enable cleared", 24'h0, {23'h0, en_q[3]});
  endtask
  // level sensing retriggers while the pin stays low, until the count runs out
  task automatic t_level();
    clear_logs();
    pin_n[1] <= 1'b0;
    setup(1, 24'h008000, 24'h000000, 16'h0002, 1'b0, 1'b1, 1'b0);
    wait_log(2);
    pin_n[1] <= 1'b1;
    chk("level second addr", 24'h008002, a_log[1]);
    chk("level single read", 24'h0, {23'h0, w_log[1]});
    repeat (3) @(posedge clk_sys);
    chk("level enable cleared", 24'h0, {23'h0, en_q[1]});
    chk("level no third", 24'h2, 24'(a_log.size()));
  endtask
  // watchdog
  initial begin
    #100us;
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    {arst_n, cfg_edge_sense, cfg_single, cfg_single_write} = 4'h0;
    {cfg_load, en_set, int_act, grant_dly, done_dly} = 20'h0;
    pin_n = 4'hf;
    {cfg_src, cfg_dst, cfg_count} = 64'h0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_dual();
    t_refuse();
    t_pair();
    t_internal();
    t_edge();
    t_level();
    complete_run();
  end
endmodule
`default_nettype wire
